// file: include/twmoc_pkg.sv
/*
  package for the timer waveform-mode and output-control block: register
  offsets, field positions, reset values, fixed top values and shared types.
  assumes a 32-bit apb register bus and a single 10 MHz clock.
*/
`default_nettype none
package twmoc_pkg;
  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] TWMOC_OFF_CTRL_A   = 12'h080; // waveform_control_a
  localparam logic [11:0] TWMOC_OFF_CTRL_B   = 12'h084; // mode high bits, run
  localparam logic [11:0] TWMOC_OFF_CMP_A    = 12'h088; // compare value a
  localparam logic [11:0] TWMOC_OFF_CMP_B    = 12'h08c; // compare value b
  localparam logic [11:0] TWMOC_OFF_CAPTURE  = 12'h090; // capture value
  localparam logic [11:0] TWMOC_OFF_COUNT    = 12'h094; // count value
  localparam logic [11:0] TWMOC_OFF_STATUS   = 12'h098; // sticky events
  localparam logic [11:0] TWMOC_OFF_MASK     = 12'h09c; // interrupt mask
  localparam logic [11:0] TWMOC_OFF_PIN_DIR  = 12'h0a0; // pin direction
  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          TWMOC_ACT_A_LSB    = 6;
  localparam int          TWMOC_ACT_B_LSB    = 4;
  localparam int          TWMOC_MODE_LO_LSB  = 0;
  localparam int          TWMOC_MODE_HI_LSB  = 3;
  localparam int          TWMOC_RUN_BIT      = 0;
  localparam int          TWMOC_ST_OVF       = 0;
  localparam int          TWMOC_ST_CMP_A     = 1;
  localparam int          TWMOC_ST_CMP_B     = 2;
  localparam logic [7:0]  TWMOC_CTRL_A_RST   = 8'h00;
  localparam logic [7:0]  TWMOC_CTRL_A_WMASK = 8'hf3;
  localparam logic [15:0] TWMOC_TOP_8BIT     = 16'h00ff;
  localparam logic [15:0] TWMOC_TOP_9BIT     = 16'h01ff;
  localparam logic [15:0] TWMOC_TOP_10BIT    = 16'h03ff;
  localparam logic [15:0] TWMOC_MAX          = 16'hffff;
  localparam logic [15:0] TWMOC_BOTTOM       = 16'h0000;
  // ----------------------------------------------------------------------
  // decoded mode kinds and per-mode attributes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TWMOC_K_NORMAL, TWMOC_K_CTC, TWMOC_K_FAST, TWMOC_K_PC, TWMOC_K_PFC, TWMOC_K_RSVD
  } twmoc_kind_t;
  typedef enum logic [1:0] {
    TWMOC_TOP_FIXED, TWMOC_TOP_CMPA, TWMOC_TOP_CAPT
  } twmoc_topsrc_t;
  typedef enum logic [1:0] {
    TWMOC_AT_IMMED, TWMOC_AT_TOP, TWMOC_AT_BOTTOM, TWMOC_AT_MAX
  } twmoc_when_t;
  typedef struct packed {
    twmoc_kind_t   kind;
    twmoc_topsrc_t top_src;
    logic [15:0]   fixed_top;
    twmoc_when_t   update_at;
    twmoc_when_t   ovf_at;
  } twmoc_mode_t;
  // waveform pin group: output, enable (low = driving), override
  typedef struct packed {
    logic out;
    logic oe_n;
    logic ovr;
  } twmoc_pin_t;
endpackage : twmoc_pkg
`default_nettype wire

// file: design/twmoc_top.sv
/*
  timer waveform-mode decode and compare-output control, with apb slave.
  assumes pclk at 10 MHz; the timer tick is a single-cycle enable made
  by a prescaler elsewhere in pclk's domain.
*/
// Added by the designer: the APB interface to the registers.
// What this block does
// [RULE_01] one clock; timer tick only enables counting, flags and buffer loads.
// [RULE_02] compare buffers load at the mode's update point, else immediately.
// [RULE_03] phase-and-frequency-correct reloads buffers and sets overflow at bottom.
// [RULE_04] control a: action a 7:6, action b 5:4, mode 1:0, 3:2 zero.
// [RULE_05] nonzero action code hands the pin to its waveform output.
// [RULE_06] waveform drives the pin only when its direction bit is output.
// [RULE_07] normal/ctc: 00 off, 01 toggle, 10 low, 11 high on match.
// [RULE_08] fast pwm code 01 toggles a only in modes 14, 15.
// [RULE_09] fast pwm 10 clears on match, sets at bottom; 11 inverse.
// [RULE_10] fast pwm: compare equal to top ignores match, bottom action kept.
// [RULE_11] dual-slope code 01 toggles a only in modes 9, 11.
// [RULE_12] dual-slope 10 clears up, sets down on match; 11 reverse.
// [RULE_13] mode is two control-b bits joined with two control-a bits.
// [RULE_14] modes 1-3 phase-correct fixed tops; 5-7 fast with same tops.
// [RULE_15] mode 0 normal, 4 and 12 ctc; immediate update, flag at max.
// [RULE_16] 10,11 phase-correct, 14,15 fast with capture/a tops; 13 reserved.
// [RULE_17] modes 8,9 phase-and-frequency-correct, load and flag at bottom.
// [RULE_18] pfc top is capture in 8, compare a in 9; reverse at top.
`timescale 1ns/1ps
`default_nettype none
module twmoc_top
  import twmoc_pkg::*;
(
  input  wire logic        pclk,        // system clock
  input  wire logic        presetn,     // async reset, active low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb direction
  input  wire logic [11:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error
  input  wire logic        timer_tick,  // count enable
  output twmoc_pin_t       pin_a,       // channel a pin group
  output twmoc_pin_t       pin_b,       // channel b pin group
  output logic             irq          // level interrupt
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [1:0]  mode_hi;
    logic        run;
    logic [15:0] cmp_buf_a;
    logic [15:0] cmp_buf_b;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] capture;
    logic [15:0] count;
    logic        down;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [1:0]  pin_dir;
    logic        wave_a;
    logic        wave_b;
    logic [31:0] rdata;
  } twmoc_state_t;

  twmoc_state_t st;
  twmoc_state_t next_st;

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  function automatic twmoc_mode_t twmoc_decode(input logic [3:0] m);
    twmoc_mode_t d;
    d = '{TWMOC_K_NORMAL, TWMOC_TOP_FIXED, TWMOC_MAX, TWMOC_AT_IMMED, TWMOC_AT_MAX};
    case (m)
      4'h0: d = '{TWMOC_K_NORMAL, TWMOC_TOP_FIXED, TWMOC_MAX,
                  TWMOC_AT_IMMED, TWMOC_AT_MAX};                   // RULE_15
      4'h1: d = '{TWMOC_K_PC, TWMOC_TOP_FIXED, TWMOC_TOP_8BIT,
                  TWMOC_AT_TOP, TWMOC_AT_BOTTOM};                  // RULE_14
      4'h2: d = '{TWMOC_K_PC, TWMOC_TOP_FIXED, TWMOC_TOP_9BIT,
                  TWMOC_AT_TOP, TWMOC_AT_BOTTOM};                  // RULE_14
      4'h3: d = '{TWMOC_K_PC, TWMOC_TOP_FIXED, TWMOC_TOP_10BIT,
                  TWMOC_AT_TOP, TWMOC_AT_BOTTOM};                  // RULE_14
      4'h4: d = '{TWMOC_K_CTC, TWMOC_TOP_CMPA, TWMOC_MAX,
                  TWMOC_AT_IMMED, TWMOC_AT_MAX};                   // RULE_15
      4'h5: d = '{TWMOC_K_FAST, TWMOC_TOP_FIXED, TWMOC_TOP_8BIT,
                  TWMOC_AT_BOTTOM, TWMOC_AT_TOP};                  // RULE_14
      4'h6: d = '{TWMOC_K_FAST, TWMOC_TOP_FIXED, TWMOC_TOP_9BIT,
                  TWMOC_AT_BOTTOM, TWMOC_AT_TOP};                  // RULE_14
      4'h7: d = '{TWMOC_K_FAST, TWMOC_TOP_FIXED, TWMOC_TOP_10BIT,
                  TWMOC_AT_BOTTOM, TWMOC_AT_TOP};                  // RULE_14
      4'h8: d = '{TWMOC_K_PFC, TWMOC_TOP_CAPT, TWMOC_MAX,
                  TWMOC_AT_BOTTOM, TWMOC_AT_BOTTOM};               // RULE_17 RULE_18
      4'h9: d = '{TWMOC_K_PFC, TWMOC_TOP_CMPA, TWMOC_MAX,
                  TWMOC_AT_BOTTOM, TWMOC_AT_BOTTOM};               // RULE_17 RULE_18
      4'ha: d = '{TWMOC_K_PC, TWMOC_TOP_CAPT, TWMOC_MAX,
                  TWMOC_AT_TOP, TWMOC_AT_BOTTOM};                  // RULE_16
      4'hb: d = '{TWMOC_K_PC, TWMOC_TOP_CMPA, TWMOC_MAX,
                  TWMOC_AT_TOP, TWMOC_AT_BOTTOM};                  // RULE_16
      4'hc: d = '{TWMOC_K_CTC, TWMOC_TOP_CAPT, TWMOC_MAX,
                  TWMOC_AT_IMMED, TWMOC_AT_MAX};                   // RULE_15
      4'hd: d = '{TWMOC_K_RSVD, TWMOC_TOP_FIXED, TWMOC_MAX,
                  TWMOC_AT_IMMED, TWMOC_AT_MAX};                   // RULE_16
      4'he: d = '{TWMOC_K_FAST, TWMOC_TOP_CAPT, TWMOC_MAX,
                  TWMOC_AT_BOTTOM, TWMOC_AT_TOP};                  // RULE_16
      4'hf: d = '{TWMOC_K_FAST, TWMOC_TOP_CMPA, TWMOC_MAX,
                  TWMOC_AT_BOTTOM, TWMOC_AT_TOP};                  // RULE_16
      default: d = '{TWMOC_K_NORMAL, TWMOC_TOP_FIXED, TWMOC_MAX,
                     TWMOC_AT_IMMED, TWMOC_AT_MAX};
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // per-channel waveform next value on match / bottom
  // ----------------------------------------------------------------------
  function automatic logic twmoc_wave(input logic [1:0]  act,
                                      input twmoc_kind_t kind,
                                      input logic        tog_ok,
                                      input logic        match,
                                      input logic        at_bot,
                                      input logic        going_down,
                                      input logic        cur);
    logic r;
    r = cur;
    case (kind)
      TWMOC_K_NORMAL, TWMOC_K_CTC: begin
        if (match) begin
          case (act)
            2'b01:   r = ~cur;                                     // RULE_07
            2'b10:   r = 1'b0;                                     // RULE_07
            2'b11:   r = 1'b1;                                     // RULE_07
            default: r = cur;                                      // RULE_07
          endcase
        end
      end
      TWMOC_K_FAST: begin
        if (act == 2'b01) begin
          if (match && tog_ok) r = ~cur;                           // RULE_08
        end else if (act[1]) begin
          if (at_bot) r = ~act[0];                                 // RULE_09
          else if (match) r = act[0];                              // RULE_09 RULE_10
        end
      end
      TWMOC_K_PC, TWMOC_K_PFC: begin
        if (match) begin
          if (act == 2'b01) begin
            if (tog_ok) r = ~cur;                                  // RULE_11
          end else if (act[1]) begin
            r = act[0] ^ going_down;                               // RULE_12
          end
        end
      end
      default: r = cur;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // combinational view of the current state
  // ----------------------------------------------------------------------
  logic [3:0]  mode_sel;
  twmoc_mode_t md;
  logic [15:0] top;
  logic        at_top;
  logic        at_bottom;
  logic        setup_ok;
  logic        wr_en;
  logic        rd_en;
  logic        addr_hit;
  logic        tog_a_ok;
  logic        dual;

  assign mode_sel  = {st.mode_hi, st.ctrl_a[TWMOC_MODE_LO_LSB +: 2]};  // RULE_13
  assign md        = twmoc_decode(mode_sel);
  assign dual      = (md.kind == TWMOC_K_PC) || (md.kind == TWMOC_K_PFC);
  assign tog_a_ok  = (md.kind == TWMOC_K_FAST) ? (mode_sel inside {4'he, 4'hf})
                                               : (mode_sel inside {4'h9, 4'hb}); // RULE_08 RULE_11
  assign at_top    = (st.count == top);
  assign at_bottom = (st.count == TWMOC_BOTTOM);
  assign setup_ok  = psel && penable;
  assign wr_en     = setup_ok && pwrite;
  assign rd_en     = psel && !penable && !pwrite;
  assign addr_hit  = paddr inside {TWMOC_OFF_CTRL_A, TWMOC_OFF_CTRL_B, TWMOC_OFF_CMP_A,
                                   TWMOC_OFF_CMP_B, TWMOC_OFF_CAPTURE, TWMOC_OFF_COUNT,
                                   TWMOC_OFF_STATUS, TWMOC_OFF_MASK, TWMOC_OFF_PIN_DIR};

  // top value from the selected source
  always_comb begin
    case (md.top_src)
      TWMOC_TOP_CMPA: top = st.cmp_a;
      TWMOC_TOP_CAPT: top = st.capture;
      default:        top = md.fixed_top;
    endcase
  end

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic       tick;
    logic       ev_ovf;
    logic       m_a;
    logic       m_b;
    logic       load;
    logic       bot_edge;
    logic [2:0] set_bits;
    tick     = 1'b0;
    ev_ovf   = 1'b0;
    m_a      = 1'b0;
    m_b      = 1'b0;
    load     = 1'b0;
    bot_edge = 1'b0;
    set_bits = 3'h0;
    next_st  = st;

    // counting, qualified by the tick; one clock only
    tick = timer_tick && st.run && (md.kind != TWMOC_K_RSVD);            // RULE_01
    if (tick) begin
      m_a = (st.count == st.cmp_a);
      m_b = (st.count == st.cmp_b);
      if (md.kind == TWMOC_K_FAST) begin
        m_a = m_a && !(st.cmp_a == top);                                  // RULE_10
        m_b = m_b && !(st.cmp_b == top);                                  // RULE_10
      end
      if (dual) begin
        if (at_top) begin
          next_st.down  = 1'b1;                                           // RULE_18
          next_st.count = st.count - 16'h0001;
        end else if (at_bottom && st.down) begin
          next_st.down  = 1'b0;
          next_st.count = st.count + 16'h0001;
        end else begin
          next_st.count = st.down ? st.count - 16'h0001 : st.count + 16'h0001;
        end
      end else if ((md.kind != TWMOC_K_NORMAL) && at_top) begin
        next_st.count = TWMOC_BOTTOM;
        bot_edge      = (md.kind == TWMOC_K_FAST);
      end else begin
        next_st.count = st.count + 16'h0001;
      end
      // overflow flag point and buffer update point
      case (md.ovf_at)
        TWMOC_AT_MAX:    ev_ovf = (st.count == TWMOC_MAX);                // RULE_15
        TWMOC_AT_TOP:    ev_ovf = at_top;                                 // RULE_14
        default:         ev_ovf = at_bottom;                              // RULE_03
      endcase
      case (md.update_at)
        TWMOC_AT_TOP:    load = at_top;                                   // RULE_02
        TWMOC_AT_BOTTOM: load = at_bottom;                                // RULE_03
        default:         load = 1'b0;
      endcase
      next_st.wave_a = twmoc_wave(st.ctrl_a[TWMOC_ACT_A_LSB +: 2], md.kind, tog_a_ok,
                                  m_a, bot_edge, st.down, st.wave_a);
      next_st.wave_b = twmoc_wave(st.ctrl_a[TWMOC_ACT_B_LSB +: 2], md.kind, 1'b0,
                                  m_b, bot_edge, st.down, st.wave_b);
    end
    if (load) begin
      next_st.cmp_a = st.cmp_buf_a;                                       // RULE_02
      next_st.cmp_b = st.cmp_buf_b;                                       // RULE_02
    end

    // register writes
    if (wr_en) begin
      case (paddr)
        TWMOC_OFF_CTRL_A:  next_st.ctrl_a  = pwdata[7:0] & TWMOC_CTRL_A_WMASK; // RULE_04
        TWMOC_OFF_CTRL_B: begin
          next_st.mode_hi = pwdata[TWMOC_MODE_HI_LSB +: 2];                // RULE_13
          next_st.run     = pwdata[TWMOC_RUN_BIT];
        end
        TWMOC_OFF_CMP_A: begin
          next_st.cmp_buf_a = pwdata[15:0];
          if (md.update_at == TWMOC_AT_IMMED) next_st.cmp_a = pwdata[15:0]; // RULE_02
        end
        TWMOC_OFF_CMP_B: begin
          next_st.cmp_buf_b = pwdata[15:0];
          if (md.update_at == TWMOC_AT_IMMED) next_st.cmp_b = pwdata[15:0]; // RULE_02
        end
        TWMOC_OFF_CAPTURE: next_st.capture = pwdata[15:0];
        TWMOC_OFF_COUNT:   next_st.count   = pwdata[15:0];
        TWMOC_OFF_STATUS:  next_st.status  = st.status & ~pwdata[2:0];
        TWMOC_OFF_MASK:    next_st.mask    = pwdata[2:0];
        TWMOC_OFF_PIN_DIR: next_st.pin_dir = pwdata[1:0];
        default:           next_st.ctrl_a  = st.ctrl_a;
      endcase
    end

    // sticky events; a set wins over a same-cycle clear
    set_bits[TWMOC_ST_OVF]   = ev_ovf;                                    // RULE_01
    set_bits[TWMOC_ST_CMP_A] = m_a;
    set_bits[TWMOC_ST_CMP_B] = m_b;
    next_st.status = next_st.status | set_bits;

    // read data captured in the setup phase
    if (rd_en) begin
      case (paddr)
        TWMOC_OFF_CTRL_A:  next_st.rdata = {24'h000000, st.ctrl_a};       // RULE_04
        TWMOC_OFF_CTRL_B:  next_st.rdata = {27'h0, st.mode_hi, 2'b00, st.run};
        TWMOC_OFF_CMP_A:   next_st.rdata = {16'h0000, st.cmp_buf_a};
        TWMOC_OFF_CMP_B:   next_st.rdata = {16'h0000, st.cmp_buf_b};
        TWMOC_OFF_CAPTURE: next_st.rdata = {16'h0000, st.capture};
        TWMOC_OFF_COUNT:   next_st.rdata = {16'h0000, st.count};
        TWMOC_OFF_STATUS:  next_st.rdata = {29'h0, st.status};
        TWMOC_OFF_MASK:    next_st.rdata = {29'h0, st.mask};
        TWMOC_OFF_PIN_DIR: next_st.rdata = {30'h0, st.pin_dir};
        default:           next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.ctrl_a <= TWMOC_CTRL_A_RST;                                      // RULE_04
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // apb answer: zero wait states, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = setup_ok && !addr_hit;
  assign prdata  = st.rdata;
  assign irq     = |(st.status & st.mask);

  // pin override and driver enable
  assign pin_a.ovr  = |st.ctrl_a[TWMOC_ACT_A_LSB +: 2];                   // RULE_05
  assign pin_b.ovr  = |st.ctrl_a[TWMOC_ACT_B_LSB +: 2];                   // RULE_05
  assign pin_a.out  = st.wave_a;
  assign pin_b.out  = st.wave_b;
  assign pin_a.oe_n = !(pin_a.ovr && st.pin_dir[0]);                      // RULE_06
  assign pin_b.oe_n = !(pin_b.ovr && st.pin_dir[1]);                      // RULE_06

endmodule // twmoc_top
`default_nettype wire

// file: testbench/twmoc_monitor.sv
/*
  checker for twmoc_top: port-level assertions, bound to the top module.
  assumes one pclk domain and presetn asynchronous, active low.
*/
`timescale 1ns/1ps
`default_nettype none
module twmoc_monitor
  import twmoc_pkg::*;
(
  input wire logic        pclk,        // system clock
  input wire logic        presetn,     // reset, active low
  input wire logic        psel,        // apb select
  input wire logic        penable,     // apb access phase
  input wire logic        pwrite,      // apb direction
  input wire logic [11:0] paddr,       // apb address
  input wire logic [31:0] pwdata,      // apb write data
  input wire logic [31:0] prdata,      // apb read data
  input wire logic        pready,      // apb ready
  input wire logic        pslverr,     // apb error
  input wire logic        timer_tick,  // count enable
  input wire twmoc_pin_t  pin_a,       // channel a pins
  input wire twmoc_pin_t  pin_b,       // channel b pins
  input wire logic        irq          // level interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic ctl_wr;
  // access phase and control a write decode
  assign acc    = psel & penable;
  assign ctl_wr = acc & pwrite & (paddr == TWMOC_OFF_CTRL_A);
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_ctrl_read_zero: assert property (acc & !pwrite & (paddr == TWMOC_OFF_CTRL_A)
    |-> prdata[31:8] == 24'h0 && prdata[3:2] == 2'b00) else $error("control a spare bits set");
  a_ovr_a_follow: assert property (ctl_wr |=> pin_a.ovr == |$past(pwdata[7:6]))
    else $error("override a wrong");
  a_ovr_b_follow: assert property (ctl_wr |=> pin_b.ovr == |$past(pwdata[5:4]))
    else $error("override b wrong");
  a_drive_a_gate: assert property (!pin_a.ovr |-> pin_a.oe_n)
    else $error("pin a driven without override");
  a_drive_b_gate: assert property (!pin_b.ovr |-> pin_b.oe_n)
    else $error("pin b driven without override");
  a_out_a_tick: assert property ($changed(pin_a.out) |-> $past(timer_tick))
    else $error("wave a moved without tick");
  a_out_b_tick: assert property ($changed(pin_b.out) |-> $past(timer_tick))
    else $error("wave b moved without tick");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(timer_tick) || $past(acc & pwrite))
    else $error("irq rose without cause");
endmodule // twmoc_monitor
bind twmoc_top twmoc_monitor u_twmoc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick), .pin_a(pin_a),
  .pin_b(pin_b), .irq(irq));
`default_nettype wire

// file: testbench/twmoc_tb_top.sv
/*
  self-checking bench for twmoc_top: registers, pin override, compare actions.
  assumes the zero-wait apb slave and the offsets of twmoc_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module twmoc_tb_top
  import twmoc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, timer_tick, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  twmoc_pin_t  pin_a, pin_b;
  int          err_count, cmp_count, cmp, n;
  logic        last_err, prev;
  logic [7:0]  r;
  twmoc_top u_twmoc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_tick(timer_tick), .pin_a(pin_a), .pin_b(pin_b), .irq(irq));
  // clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic tick(input int n);
    @(posedge pclk);
    timer_tick <= 1'b1;
    repeat (n) @(posedge pclk);
    timer_tick <= 1'b0;
    #1;
  endtask
  task automatic mode(input logic [3:0] m, input logic [7:0] act);
    apb(1'b1, TWMOC_OFF_CTRL_A, {24'h0, act[7:4], 2'b00, m[1:0]});
    apb(1'b1, TWMOC_OFF_CTRL_B, {27'h0, m[3:2], 2'b00, 1'b1});
  endtask
  task automatic restart(input int v);
    apb(1'b1, TWMOC_OFF_CTRL_B, 32'h0);
    apb(1'b1, TWMOC_OFF_CTRL_A, 32'h0);
    apb(1'b1, TWMOC_OFF_COUNT, 32'h0);
    apb(1'b1, TWMOC_OFF_CMP_A, v);
    apb(1'b1, TWMOC_OFF_CMP_B, v);
    apb(1'b1, TWMOC_OFF_STATUS, 32'h7);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // expected top of a mode, t being the value in compare a and capture
  function automatic int exp_top(input int m, input int t);
    case (m)
      0:       return int'(TWMOC_MAX);
      1, 5:    return int'(TWMOC_TOP_8BIT);
      2, 6:    return int'(TWMOC_TOP_9BIT);
      3, 7:    return int'(TWMOC_TOP_10BIT);
      default: return t;
    endcase
  endfunction
  // expected count after n ticks from zero: up and down in dual-slope modes
  function automatic int exp_count(input int m, input int n, input int t);
    int top;
    int k;
    top = exp_top(m, t);
    if (m inside {[1:3], [8:11]}) begin
      k = n % (2 * top);
      return (k <= top) ? k : 2 * top - k;
    end
    return n % (top + 1);
  endfunction
  // watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    conclude();
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    timer_tick = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h17eba564));
    apb(1'b0, TWMOC_OFF_CTRL_A, 32'h0);
    chk(rd, {24'h0, TWMOC_CTRL_A_RST});
    chk(32'({pin_a.ovr, pin_a.oe_n, pin_b.ovr, pin_b.oe_n}), 32'h5);
    apb(1'b0, 12'h0a4, 32'h0);
    chk(rd, 32'h0);
    chk(32'(last_err), 32'h1);
    $display("test reset done");
    // random control a and pin direction
    for (int i = 0; i < 8; i++) begin
      r = 8'($urandom);
      d = $urandom;
      apb(1'b1, TWMOC_OFF_PIN_DIR, {30'h0, d[1:0]});
      apb(1'b1, TWMOC_OFF_CTRL_A, {24'h0, r});
      apb(1'b0, TWMOC_OFF_CTRL_A, 32'h0);
      chk(rd, {24'h0, r & TWMOC_CTRL_A_WMASK});
      chk(32'({pin_a.ovr, pin_a.oe_n}), 32'({|r[7:6], !(|r[7:6] & d[0])}));
      chk(32'({pin_b.ovr, pin_b.oe_n}), 32'({|r[5:4], !(|r[5:4] & d[1])}));
    end
    $display("test override done");
    // normal mode: toggle, clear, set, with mask and clear of events
    apb(1'b1, TWMOC_OFF_PIN_DIR, 32'h3);
    prev = 1'b0;
    for (int c = 1; c < 4; c++) begin
      cmp = $urandom_range(20, 2);
      restart(cmp);
      apb(1'b1, TWMOC_OFF_MASK, (c == 2) ? 32'h0 : 32'h6);
      mode(4'd0, {c[1:0], c[1:0], 4'h0});
      tick(cmp);
      chk(32'({pin_a.out, pin_b.out, irq}), 32'({prev, prev, 1'b0}));
      tick(1);
      prev = (c == 1) ? ~prev : (c == 3);
      chk(32'({pin_a.out, pin_b.out, irq}), 32'({prev, prev, c != 2}));
      apb(1'b1, TWMOC_OFF_STATUS, 32'h7);
      chk(32'(irq), 32'h0);
    end
    $display("test normal done");
    // fast pwm 8-bit, non-inverting on a
    cmp = $urandom_range(200, 10);
    restart(cmp);
    mode(4'd5, 8'h80);
    tick(cmp + 1);
    chk(32'(pin_a.out), 32'h0);
    tick(254 - cmp);
    apb(1'b0, TWMOC_OFF_STATUS, 32'h0);
    chk(32'({rd[0], pin_a.out}), 32'h0);
    tick(1);
    apb(1'b0, TWMOC_OFF_STATUS, 32'h0);
    chk(32'({rd[0], pin_a.out}), 32'h3);
    $display("test fast done");
    // phase correct 8-bit: clear going up, set going down
    cmp = $urandom_range(200, 10);
    restart(cmp);
    mode(4'd1, 8'h80);
    tick(cmp + 1);
    chk(32'(pin_a.out), 32'h0);
    tick(509 - 2 * cmp);
    chk(32'(pin_a.out), 32'h0);
    tick(1);
    chk(32'(pin_a.out), 32'h1);
    $display("test dual slope done");
    // reserved mode never counts
    restart(5);
    mode(4'd13, 8'h00);
    tick(5);
    apb(1'b0, TWMOC_OFF_COUNT, 32'h0);
    chk(rd, 32'h0);
    $display("test reserved done");
    // count sequence and top source of every counting mode
    for (int m = 0; m < 16; m++) begin
      if (m == 13) continue;
      cmp = $urandom_range(300, 20);
      n = $urandom_range(2100, 50);
      restart(cmp);
      apb(1'b1, TWMOC_OFF_CAPTURE, cmp);
      mode(4'(m), 8'h00);
      tick(n);
      apb(1'b0, TWMOC_OFF_COUNT, 32'h0);
      chk(rd, 32'(exp_count(m, n, cmp)));
    end
    $display("test modes done");
    conclude();
  end
endmodule // twmoc_tb_top
`default_nettype wire
